// [hw/scsi_sequencer_vector_and_block_regs.sv]
// Sequencer start vectors, port memory pointer and byte counter, block ratio and size.
// Assumes a multiplexed 8-bit processor port on pins; sequencer and FIFO on sys_clk.
// Functional notes
// R1: Selection with selection hold set starts sequencer at selection vector.
// R2: Reselection with reselection hold set starts initiator sequence at reselection vector.
// R3: DMA request with auto response set starts sequencer at DMA vector.
// R4: Pointer register is read-only and shows the 6-bit memory location.
// R5: Pointer holds next location and advances by one per byte moved.
// R6: Each transfer instruction loads pointer from its memory address field; code loads it only when idle, not while a transfer is active.
// R7: Outgoing transfers burst-copy memory into FIFO, pointer advances at once.
// R8: Incoming bytes advance pointer only as each enters memory from FIFO.
// R9: Outgoing transfer reported complete on the bus only when FIFO empty.
// R10: Read-only 4-bit counter gives bytes still to move.
// R11: Outgoing counter reaches zero when burst copy into FIFO ends.
// R12: Incoming counter reaches zero when final byte is written to memory.
// R13: Ratio field holds blocks minus one; values 0..15 decode to 1..16.
// R14: Processor programs block size as bytes per block minus one.
// R15: Low size register holds bits 7..0, high holds bits 11..8.
// R16: Unused upper bits read zero; writes to read-only registers ignored.
// R17: Start vectors are 7-bit control store addresses.
`default_nettype none
module scsi_sequencer_vector_and_block_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] adIn,
  output logic [7:0] adOut,
  output logic adOe,
  input wire logic aleIn,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic chipSelectN,
  input wire logic beingSelected,
  input wire logic reselectionDone,
  input wire logic dmaRequestPin,
  input wire logic selectionHoldFlag,
  input wire logic reselectionHoldFlag,
  input wire logic autoResponseFlag,
  output logic seqStart,
  output logic [6:0] seqStartAddr,
  input wire logic xferStart,
  input wire logic [5:0] instrMemAddrField,
  input wire logic [3:0] xferLength,
  input wire logic xferToScsi,
  input wire logic fifoReady,
  input wire logic fifoHasData,
  input wire logic fifoEmpty,
  output logic [5:0] portMemoryPointer,
  output logic memRead,
  output logic memWrite,
  output logic xferActive,
  output logic xferBusDone,
  output logic [3:0] physicalLogicalRatio,
  output logic [4:0] blocksPerLogical,
  output logic [11:0] physicalBlockSize
);

  function automatic logic [7:0] zeroExtend(input logic [7:0] value, input int width);
    logic [7:0] mask;
    mask = 8'hFF >> (8 - width);
    return value & mask;
  endfunction

  function automatic logic [4:0] decodeRatio(input logic [3:0] field);
    return {1'b0, field} + 5'h01;
  endfunction

  // Pin synchronisers: bus has two stages; ALE, strobes, chip select and DMA request have three
  logic [7:0] adS1_q, adS2_q;
  logic aleS1_q, aleS2_q, aleS3_q;
  logic weS1_q, weS2_q, weS3_q;
  logic reS1_q, reS2_q, reS3_q;
  logic csS1_q, csS2_q, csS3_q;
  logic drqS1_q, drqS2_q, drqS3_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      adS1_q <= seq_vector_regs_pkg::DATA_RST;
      adS2_q <= seq_vector_regs_pkg::DATA_RST;
      {aleS1_q, aleS2_q, aleS3_q} <= 3'h0;
      {weS1_q, weS2_q, weS3_q} <= 3'h7;
      {reS1_q, reS2_q, reS3_q} <= 3'h7;
      {csS1_q, csS2_q, csS3_q} <= 3'h7;
      {drqS1_q, drqS2_q, drqS3_q} <= 3'h0;
    end
    else
    begin
      adS1_q <= adIn;
      adS2_q <= adS1_q;
      {aleS1_q, aleS2_q, aleS3_q} <= {aleIn, aleS1_q, aleS2_q};
      {weS1_q, weS2_q, weS3_q} <= {writeStrobeN, weS1_q, weS2_q};
      {reS1_q, reS2_q, reS3_q} <= {readStrobeN, reS1_q, reS2_q};
      {csS1_q, csS2_q, csS3_q} <= {chipSelectN, csS1_q, csS2_q};
      {drqS1_q, drqS2_q, drqS3_q} <= {dmaRequestPin, drqS1_q, drqS2_q};
    end
  end

  // Address is captured as ALE falls; write happens as the write strobe rises
  wire aleFall = aleS3_q & ~aleS2_q;
  wire writeEnd = ~weS3_q & weS2_q & ~csS3_q;
  wire readOn = ~reS2_q & ~csS2_q;

  logic [7:0] addr_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      addr_q <= seq_vector_regs_pkg::DATA_RST;
    else if (aleFall)
      addr_q <= adS2_q;
  end

  wire hitSel = addr_q == seq_vector_regs_pkg::SEL_VEC_OFS;
  wire hitResel = addr_q == seq_vector_regs_pkg::RESEL_VEC_OFS;
  wire hitDma = addr_q == seq_vector_regs_pkg::DMA_VEC_OFS;
  wire hitPtr = addr_q == seq_vector_regs_pkg::PTR_OFS;
  wire hitCnt = addr_q == seq_vector_regs_pkg::CNT_OFS;
  wire hitRatio = addr_q == seq_vector_regs_pkg::RATIO_OFS;
  wire hitSizeLo = addr_q == seq_vector_regs_pkg::SIZE_LO_OFS;
  wire hitSizeHi = addr_q == seq_vector_regs_pkg::SIZE_HI_OFS;
  wire hitAny = hitSel | hitResel | hitDma | hitPtr | hitCnt | hitRatio | hitSizeLo | hitSizeHi;

  // Writable registers; pointer and counter have no write path
  logic [6:0] selVec_q, reselVec_q, dmaVec_q;
  logic [3:0] ratio_q;
  logic [4:0] ratioCount_q;
  logic [11:0] size_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      selVec_q <= seq_vector_regs_pkg::VEC_RST;
      reselVec_q <= seq_vector_regs_pkg::VEC_RST;
      dmaVec_q <= seq_vector_regs_pkg::VEC_RST;
      ratio_q <= seq_vector_regs_pkg::RATIO_RST;
      ratioCount_q <= decodeRatio(seq_vector_regs_pkg::RATIO_RST);
      size_q <= seq_vector_regs_pkg::SIZE_RST;
    end
    else if (writeEnd)
    begin
      if (hitSel)
        selVec_q <= adS2_q[6:0]; // R17
      if (hitResel)
        reselVec_q <= adS2_q[6:0];
      if (hitDma)
        dmaVec_q <= adS2_q[6:0];
      if (hitRatio)
      begin
        ratio_q <= adS2_q[3:0];
        ratioCount_q <= decodeRatio(adS2_q[3:0]); // R13
      end
      if (hitSizeLo)
        size_q[7:0] <= adS2_q; // R15
      if (hitSizeHi)
        size_q[11:8] <= adS2_q[3:0]; // R15
    end
  end

  assign physicalLogicalRatio = ratio_q;
  assign blocksPerLogical = ratioCount_q;
  assign physicalBlockSize = size_q; // R14

  // Transfer engine between port memory and FIFO
  seq_vector_regs_pkg::xfer_state_t state_q;
  logic [5:0] ptr_q;
  logic [3:0] cnt_q;
  logic busDone_q;

  wire cntZero = cnt_q == seq_vector_regs_pkg::CNT_RST;
  assign memRead = (state_q == seq_vector_regs_pkg::XFER_OUT) && fifoReady && !cntZero; // R7
  assign memWrite = (state_q == seq_vector_regs_pkg::XFER_IN) && fifoHasData && !cntZero; // R8
  wire byteMoved = memRead | memWrite;
  wire outDone = (state_q == seq_vector_regs_pkg::XFER_OUT) && cntZero && fifoEmpty;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= seq_vector_regs_pkg::XFER_IDLE;
      ptr_q <= seq_vector_regs_pkg::PTR_RST;
      cnt_q <= seq_vector_regs_pkg::CNT_RST;
      busDone_q <= 1'b0;
    end
    else
    begin
      busDone_q <= outDone; // R9
      case (state_q)
        seq_vector_regs_pkg::XFER_IDLE:
        begin
          if (xferStart)
          begin
            ptr_q <= instrMemAddrField; // R6
            cnt_q <= xferLength; // R10
            state_q <= xferToScsi ? seq_vector_regs_pkg::XFER_OUT
                                  : seq_vector_regs_pkg::XFER_IN;
          end
        end
        seq_vector_regs_pkg::XFER_OUT:
        begin
          if (byteMoved)
          begin
            ptr_q <= ptr_q + 6'h01; // R5
            cnt_q <= cnt_q - 4'h1; // R11
          end
          if (outDone)
            state_q <= seq_vector_regs_pkg::XFER_IDLE; // R9
        end
        seq_vector_regs_pkg::XFER_IN:
        begin
          if (byteMoved)
          begin
            ptr_q <= ptr_q + 6'h01; // R5
            cnt_q <= cnt_q - 4'h1; // R12
          end
          else if (cntZero)
            state_q <= seq_vector_regs_pkg::XFER_IDLE; // R12
        end
        default:
          state_q <= seq_vector_regs_pkg::XFER_IDLE;
      endcase
    end
  end

  assign portMemoryPointer = ptr_q; // R4
  assign xferActive = state_q != seq_vector_regs_pkg::XFER_IDLE;
  assign xferBusDone = busDone_q;

  // Sequencer start: one pulse per rising edge of a cause; on a tie selection beats reselection beats DMA
  logic selPrev_q, reselPrev_q;
  logic start_q;
  logic [6:0] startAddr_q;

  wire selEvent = beingSelected & ~selPrev_q & selectionHoldFlag;
  wire reselEvent = reselectionDone & ~reselPrev_q & reselectionHoldFlag;
  wire dmaEvent = drqS2_q & ~drqS3_q & autoResponseFlag;
  wire [6:0] startPick = selEvent ? selVec_q : (reselEvent ? reselVec_q : dmaVec_q);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      selPrev_q <= 1'b0;
      reselPrev_q <= 1'b0;
      start_q <= 1'b0;
      startAddr_q <= seq_vector_regs_pkg::VEC_RST;
    end
    else
    begin
      selPrev_q <= beingSelected;
      reselPrev_q <= reselectionDone;
      start_q <= selEvent | reselEvent | dmaEvent; // R1 R2 R3
      if (selEvent | reselEvent | dmaEvent)
        startAddr_q <= startPick; // R1 R2 R3
    end
  end

  assign seqStart = start_q;
  assign seqStartAddr = startAddr_q;

  // Read path: data registered, narrow fields zero-extended
  logic [7:0] readMux;
  always_comb
  begin
    readMux = seq_vector_regs_pkg::DATA_RST;
    if (hitSel)
      readMux = zeroExtend({1'b0, selVec_q}, seq_vector_regs_pkg::VEC_W); // R16
    if (hitResel)
      readMux = zeroExtend({1'b0, reselVec_q}, seq_vector_regs_pkg::VEC_W);
    if (hitDma)
      readMux = zeroExtend({1'b0, dmaVec_q}, seq_vector_regs_pkg::VEC_W);
    if (hitPtr)
      readMux = zeroExtend({2'b00, ptr_q}, seq_vector_regs_pkg::PTR_W); // R4
    if (hitCnt)
      readMux = zeroExtend({4'h0, cnt_q}, seq_vector_regs_pkg::CNT_W); // R10
    if (hitRatio)
      readMux = zeroExtend({4'h0, ratio_q}, seq_vector_regs_pkg::RATIO_W);
    if (hitSizeLo)
      readMux = size_q[7:0];
    if (hitSizeHi)
      readMux = zeroExtend({4'h0, size_q[11:8]}, seq_vector_regs_pkg::SIZE_HI_W); // R16
  end

  logic [7:0] readData_q;
  logic readOe_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      readData_q <= seq_vector_regs_pkg::DATA_RST;
      readOe_q <= 1'b0;
    end
    else
    begin
      readData_q <= readMux;
      readOe_q <= readOn & hitAny;
    end
  end

  assign adOut = readData_q;
  assign adOe = readOe_q;

endmodule
`default_nettype wire

// [hw/seq_vector_regs_pkg.sv]
// Constants for the sequencer vector and block register group.
// Assumes an 8-bit register port with byte offsets as printed.
`default_nettype none
package seq_vector_regs_pkg;
  localparam int DATA_W = 8;
  localparam int VEC_W = 7;
  localparam int PTR_W = 6;
  localparam int CNT_W = 4;
  localparam int RATIO_W = 4;
  localparam int SIZE_W = 12;
  localparam int SIZE_LO_W = 8;
  localparam int SIZE_HI_W = 4;

  localparam logic [7:0] SEL_VEC_OFS = 8'h2C;
  localparam logic [7:0] RESEL_VEC_OFS = 8'h2E;
  localparam logic [7:0] DMA_VEC_OFS = 8'h30;
  localparam logic [7:0] PTR_OFS = 8'h32;
  localparam logic [7:0] CNT_OFS = 8'h34;
  localparam logic [7:0] RATIO_OFS = 8'h36;
  localparam logic [7:0] SIZE_LO_OFS = 8'h38;
  localparam logic [7:0] SIZE_HI_OFS = 8'h3A;

  localparam logic [VEC_W-1:0] VEC_RST = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [RATIO_W-1:0] RATIO_RST = 4'h0;
  localparam logic [SIZE_W-1:0] SIZE_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum {XFER_IDLE, XFER_OUT, XFER_IN} xfer_state_t;
endpackage
`default_nettype wire

// [verification/seq_vector_regs_props.sv]
// Assertions on the sequencer vector and block register group ports.
// Bound into the top module; sees only its ports, one clock domain.
`default_nettype none
module seq_vector_regs_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic beingSelected,
  input wire logic selectionHoldFlag,
  input wire logic seqStart,
  input wire logic xferStart,
  input wire logic [5:0] instrMemAddrField,
  input wire logic fifoReady,
  input wire logic fifoHasData,
  input wire logic fifoEmpty,
  input wire logic [5:0] portMemoryPointer,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic xferActive,
  input wire logic xferBusDone,
  input wire logic [3:0] physicalLogicalRatio,
  input wire logic [4:0] blocksPerLogical
);
  timeunit 1ns / 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_SEL: assert property ($rose(beingSelected) && selectionHoldFlag |=> seqStart)
    else $error("selection start missing");
  AST_LOAD: assert property (xferStart && !xferActive |=>
    portMemoryPointer == $past(instrMemAddrField)) else $error("pointer not loaded");
  AST_STEP: assert property (memRead || memWrite |=>
    portMemoryPointer == $past(portMemoryPointer) + 6'h01) else $error("pointer step");
  AST_HOLD: assert property (!memRead && !memWrite && !(xferStart && !xferActive) |=>
    $stable(portMemoryPointer)) else $error("pointer moved");
  AST_PUSH: assert property (memRead |-> fifoReady && xferActive)
    else $error("push without room");
  AST_POP: assert property (memWrite |-> fifoHasData && xferActive)
    else $error("pop without data");
  AST_DONE: assert property (xferBusDone |-> $past(fifoEmpty) && !xferActive)
    else $error("done before empty");
  AST_RATIO: assert property (blocksPerLogical == {1'b0, physicalLogicalRatio} + 5'h01)
    else $error("ratio decode");
  COV_START: cover property (seqStart);
  COV_DONE: cover property (xferBusDone);
  COV_POP: cover property (memWrite);
endmodule
bind scsi_sequencer_vector_and_block_regs seq_vector_regs_props i_props (.sys_clk, .sys_rst,
  .beingSelected, .selectionHoldFlag, .seqStart, .xferStart, .instrMemAddrField, .fifoReady,
  .fifoHasData, .fifoEmpty, .portMemoryPointer, .memRead, .memWrite, .xferActive,
  .xferBusDone, .physicalLogicalRatio, .blocksPerLogical);
`default_nettype wire

// [verification/cpu_port_model.sv]
// Processor side of the multiplexed register port.
// Assumes cycle() is called from one process, at falling edges of sys_clk.
`default_nettype none
module cpu_port_model (
  input wire logic sys_clk,
  output wire logic [7:0] adIn,
  output logic aleIn,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic chipSelectN,
  input wire logic [7:0] adOut,
  input wire logic adOe
);
  timeunit 1ns / 1ns;
  logic [7:0] drv = 8'h00;
  logic drvOn = 1'b1;
  initial {aleIn, writeStrobeN, readStrobeN, chipSelectN} = 4'b0111;
  // Released bus shows the inverse of the last value, not a stale copy
  assign adIn = drvOn ? drv : (adOe ? adOut : ~drv);
  task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic wr,
    output logic [7:0] q, output logic oe);
    q = 8'h00;
    oe = 1'b0;
    @(negedge sys_clk);
    {aleIn, chipSelectN, drv, drvOn} = {2'b10, a, 1'b1};
    repeat (4) @(negedge sys_clk);
    aleIn = 1'b0;
    repeat (4) @(negedge sys_clk);
    {drv, drvOn, writeStrobeN, readStrobeN} = {wr ? d : ~a, wr, ~wr, wr};
    repeat (8)
    begin
      @(negedge sys_clk);
      if (!wr && !oe && adOe === 1'b1)
        {oe, q} = {1'b1, adOut};
    end
    {writeStrobeN, readStrobeN} = 2'b11;
    repeat (4) @(negedge sys_clk);
    {chipSelectN, drv} = {1'b1, ~drv};
  endtask
endmodule
`default_nettype wire

// [verification/scsi_sequencer_vector_and_block_regs_bench.sv]
// Self-checking bench for the sequencer vector and block register group.
// Assumes cpu_port_model for register cycles; inputs change at falling edges.
`default_nettype none
module scsi_sequencer_vector_and_block_regs_bench;
  timeunit 1ns / 1ns;
  logic sys_clk = 1'b0, sys_rst = 1'b1, xferStart = 1'b0, xferToScsi = 1'b0;
  logic beingSelected = 1'b0, reselectionDone = 1'b0, dmaRequestPin = 1'b0;
  logic selectionHoldFlag = 1'b0, reselectionHoldFlag = 1'b0, autoResponseFlag = 1'b0;
  logic fifoReady = 1'b0, fifoHasData = 1'b0, fifoEmpty = 1'b1, oe, got;
  logic adOe, seqStart, memRead, memWrite, xferActive, xferBusDone;
  logic [5:0] instrMemAddrField = 6'h00, portMemoryPointer;
  logic [3:0] xferLength = 4'h0, physicalLogicalRatio;
  logic [6:0] seqStartAddr;
  logic [4:0] blocksPerLogical;
  logic [11:0] physicalBlockSize;
  logic [7:0] adOut, q, mdl [8];
  logic [31:0] seed = 32'hC52D;
  wire logic [7:0] adIn;
  wire logic aleIn, writeStrobeN, readStrobeN, chipSelectN;
  int failures = 0, num_checks = 0, i, n;
  logic [7:0] ofs [8] = '{8'h2C, 8'h2E, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A};
  logic [7:0] msk [8] = '{8'h7F, 8'h7F, 8'h7F, 8'h00, 8'h00, 8'h0F, 8'hFF, 8'h0F};
  always #5 sys_clk = ~sys_clk;
  scsi_sequencer_vector_and_block_regs i_dut (.sys_clk, .sys_rst, .adIn, .adOut, .adOe, .aleIn,
    .writeStrobeN, .readStrobeN, .chipSelectN, .beingSelected, .reselectionDone, .dmaRequestPin,
    .selectionHoldFlag, .reselectionHoldFlag, .autoResponseFlag, .seqStart, .seqStartAddr,
    .xferStart, .instrMemAddrField, .xferLength, .xferToScsi, .fifoReady, .fifoHasData,
    .fifoEmpty, .portMemoryPointer, .memRead, .memWrite, .xferActive, .xferBusDone,
    .physicalLogicalRatio, .blocksPerLogical, .physicalBlockSize);
  cpu_port_model i_cpu (.sys_clk, .adIn, .aleIn, .writeStrobeN, .readStrobeN, .chipSelectN,
    .adOut, .adOe);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
    i_cpu.cycle(a, d, wr, q, oe);
  endtask
  initial
  begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      acc(ofs[i], 8'h00, 1'b0);
      chk({oe, q}, 9'h100);
      seed = lfsr(seed);
      acc(ofs[i], seed[7:0], 1'b1);
      mdl[i] = seed[7:0] & msk[i];
    end
    acc(8'h3C, 8'h5A, 1'b1);
    acc(8'h3C, 8'h00, 1'b0);
    chk(oe, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      acc(ofs[i], 8'h00, 1'b0);
      chk({oe, q}, {1'b1, mdl[i]});
    end
    chk({physicalBlockSize, physicalLogicalRatio, blocksPerLogical},
      {mdl[7][3:0], mdl[6], mdl[5][3:0], mdl[5][4:0] + 5'h01});
    $display("test registers done");
    for (i = 0; i < 6; i++)
    begin
      {selectionHoldFlag, reselectionHoldFlag, autoResponseFlag} = {3{i[0]}};
      {beingSelected, reselectionDone, dmaRequestPin} = 3'b100 >> (i / 2);
      got = 1'b0;
      repeat (6)
      begin
        @(negedge sys_clk);
        got = got | (seqStart === 1'b1);
      end
      chk({got, i[0] ? seqStartAddr : 7'h00}, {i[0], i[0] ? mdl[i / 2][6:0] : 7'h00});
      {beingSelected, reselectionDone, dmaRequestPin} = 3'b000;
      repeat (4) @(negedge sys_clk);
    end
    $display("test start vectors done");
    {instrMemAddrField, xferLength} = {6'h3E, 4'h3};
    {xferToScsi, fifoEmpty, xferStart, n} = {3'b101, 32'd0};
    repeat (30)
    begin
      @(negedge sys_clk);
      seed = lfsr(seed);
      {xferStart, fifoReady} = {1'b0, seed[0]};
      // Strobe is combinational: take it as the coming edge sees it
      @(posedge sys_clk);
      n += (memRead === 1'b1);
    end
    @(negedge sys_clk);
    chk({n[3:0], portMemoryPointer, xferActive}, {4'h3, 6'h01, 1'b1});
    // A new instruction while one is active must not reload the pointer
    xferStart = 1'b1;
    acc(8'h34, 8'h00, 1'b0);
    chk(q, 8'h00);
    acc(8'h32, 8'h00, 1'b0);
    chk(q, 8'h01);
    {fifoEmpty, got, xferStart} = 3'b100;
    for (n = 0; n < 20 && !got; n++)
    begin
      @(negedge sys_clk);
      got = (xferBusDone === 1'b1);
    end
    chk(got, 1'b1);
    if (!got)
      test_done();
    $display("test outgoing done");
    seed = lfsr(seed);
    {instrMemAddrField, xferLength, xferToScsi, fifoHasData} = {seed[5:0], 4'hF, 2'b00};
    xferStart = 1'b1;
    @(negedge sys_clk);
    xferStart = 1'b0;
    acc(8'h34, 8'h00, 1'b0);
    chk(q, 8'h0F);
    acc(8'h32, 8'h00, 1'b0);
    chk(q, {2'b00, instrMemAddrField});
    n = 0;
    for (i = 0; i < 300 && xferActive === 1'b1; i++)
    begin
      seed = lfsr(seed);
      fifoHasData = seed[0];
      @(posedge sys_clk);
      n += (memWrite === 1'b1);
      @(negedge sys_clk);
    end
    chk({n[4:0], xferActive}, {5'd15, 1'b0});
    if (xferActive !== 1'b0)
      test_done();
    chk(portMemoryPointer, 6'(instrMemAddrField + 6'h0F));
    acc(8'h34, 8'h00, 1'b0);
    chk(q, 8'h00);
    $display("test incoming done");
    test_done();
  end
endmodule
`default_nettype wire
